//--- include/level_if.sv
// Carrier between a level field and its decoder
`timescale 1ns/100ps
interface level_if;
  logic [3:0] code;
  logic connected;
  logic [4:0] attenHalfDb;
  logic reserved;

  modport src (output code, input connected, input attenHalfDb, input reserved);
  modport dec (input code, output connected, output attenHalfDb, output reserved);
endinterface

//--- include/mix_ctrl_pkg.sv
// Constants and types shared by the ADC input mix control register bank
package mix_ctrl_pkg;

  // Register addresses on the control port
  localparam logic [7:0] AUX_MIC_RIGHT_OFFSET = 8'h12;
  localparam logic [7:0] LINE_LEFT_OFFSET = 8'h13;

  // Reset values
  localparam logic [7:0] AUX_MIC_RIGHT_RESET = 8'hFF;
  localparam logic [7:0] LINE_LEFT_RESET = 8'h78;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Field positions, aux microphone register
  localparam int MIC_LEFT_LVL_MSB = 7;
  localparam int MIC_LEFT_LVL_LSB = 4;
  localparam int MIC_RIGHT_LVL_MSB = 3;
  localparam int MIC_RIGHT_LVL_LSB = 0;

  // Field positions, line-one-left register
  localparam int LINE_DIFF_BIT = 7;
  localparam int LINE_LVL_MSB = 6;
  localparam int LINE_LVL_LSB = 3;
  localparam int ADC_POWER_BIT = 2;
  localparam int STEP_RATE_MSB = 1;
  localparam int STEP_RATE_LSB = 0;

  // Shared level encoding
  localparam logic [3:0] LEVEL_MAX_CODE = 4'h8;
  localparam logic [3:0] LEVEL_DISCONNECT = 4'hF;
  localparam logic [4:0] ATTEN_HALF_DB_PER_CODE = 5'h03;

  // Left PGA gain in 0.5 dB units
  localparam logic [6:0] PGA_GAIN_RESET = 7'h00;

  typedef enum logic [1:0] {
    RATE_EVERY_FS = 2'b00,
    RATE_EVERY_TWO_FS = 2'b01,
    RATE_IMMEDIATE_A = 2'b10,
    RATE_IMMEDIATE_B = 2'b11
  } step_rate_t;

endpackage

//--- logic/adc_input_mix_control_regs.sv
// Record-path input mix control registers with left PGA soft-stepping
// Behaviour
// - Upper nibble of mic register sets left aux mic level into right mix.
// - Any valid level code connects the input; 1111 disconnects it.
// - Lower nibble sets right aux mic level, same encoding, resets 1111.
// - Lower nibble 1111 keeps right aux mic off the right mix.
// - Line register bit 7 picks single-ended (0) or differential (1), resets 0.
// - Line bits 6..3 set line level into left mix, reset 1111 disconnected.
// - Line bit 2 powers the left ADC channel up when 1, resets 0.
// - Bits 1..0: 00 steps per sample, 01 per two samples, resets 00.
// - Soft-step codes 10 and 11 apply gain changes immediately.
`timescale 1ns/100ps
module adc_input_mix_control_regs (
  input wire logic clk, // System clock, 125 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic regWrEn, // Register write strobe
  input wire logic regRdEn, // Register read strobe
  input wire logic [7:0] regAddr, // Register address
  input wire logic [7:0] regWrData, // Write data
  output logic [7:0] regRdData, // Read data, registered
  output logic regRdValid, // Read data valid, one cycle
  input wire logic fsTick, // Sample-period pulse
  input wire logic [6:0] pgaGainTarget, // Requested left PGA gain, 0.5 dB units
  input wire logic reservedClear, // Clears the reserved-code flag
  output logic [6:0] pgaGainApplied, // Left PGA gain now applied
  output logic pgaGainSettled, // Applied gain equals the target
  output logic micLeftConnected, // Left aux mic on right mix
  output logic [4:0] micLeftAtten, // Its attenuation, 0.5 dB units
  output logic micRightConnected, // Right aux mic on right mix
  output logic [4:0] micRightAtten, // Its attenuation, 0.5 dB units
  output logic lineConnected, // First left line on left mix
  output logic [4:0] lineAtten, // Its attenuation, 0.5 dB units
  output logic lineDifferential, // Line input fully differential
  output logic leftAdcPowerUp, // Left ADC channel powered
  output logic reservedCodeSeen // A reserved level code was written
);
  logic [7:0] micReg_r;
  logic [7:0] micReg_nxt;
  logic [7:0] lineReg_r;
  logic [7:0] lineReg_nxt;
  logic [7:0] rdData_r;
  logic rdValid_r;
  logic [6:0] gain_r;
  logic [6:0] gain_nxt;
  logic reserved_r;
  logic reserved_nxt;
  logic micLeftConn_r;
  logic micRightConn_r;
  logic lineConn_r;
  logic [4:0] micLeftAtten_r;
  logic [4:0] micRightAtten_r;
  logic [4:0] lineAtten_r;

  wire hitMic;
  wire hitLine;
  wire wrMic;
  wire wrLine;
  wire [7:0] rdMux;
  wire stepNow;
  wire immediate;
  wire gainBelow;
  wire gainAbove;
  wire anyReserved;
  mix_ctrl_pkg::step_rate_t rate;

  level_if micLeftLv ();
  level_if micRightLv ();
  level_if lineLv ();

  // Address decode
  assign hitMic = (regAddr == mix_ctrl_pkg::AUX_MIC_RIGHT_OFFSET);
  assign hitLine = (regAddr == mix_ctrl_pkg::LINE_LEFT_OFFSET);
  assign wrMic = regWrEn && hitMic;
  assign wrLine = regWrEn && hitLine;

  // All eight bits of both registers are plain read/write storage
  assign micReg_nxt = wrMic ? regWrData : micReg_r;
  assign lineReg_nxt = wrLine ? regWrData : lineReg_r;

  // Read back the stored values untouched; unmapped addresses read zero
  assign rdMux = hitMic ? micReg_r :
                 hitLine ? lineReg_r :
                 mix_ctrl_pkg::UNMAPPED_READ;

  // Field extraction
  assign micLeftLv.code =
      micReg_r[mix_ctrl_pkg::MIC_LEFT_LVL_MSB:mix_ctrl_pkg::MIC_LEFT_LVL_LSB];
  assign micRightLv.code =
      micReg_r[mix_ctrl_pkg::MIC_RIGHT_LVL_MSB:mix_ctrl_pkg::MIC_RIGHT_LVL_LSB];
  assign lineLv.code =
      lineReg_r[mix_ctrl_pkg::LINE_LVL_MSB:mix_ctrl_pkg::LINE_LVL_LSB];
  assign rate = mix_ctrl_pkg::step_rate_t'(
      lineReg_r[mix_ctrl_pkg::STEP_RATE_MSB:mix_ctrl_pkg::STEP_RATE_LSB]);

  level_decode micLeftDec (
    .lv(micLeftLv)
  );

  level_decode micRightDec (
    .lv(micRightLv)
  );

  level_decode lineDec (
    .lv(lineLv)
  );

  soft_step_pacer pacer (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .fsTick(fsTick),
    .rate(rate),
    .stepNow(stepNow),
    .immediate(immediate)
  );

  // Gain ramp: one 0.5 dB step per paced tick, or a jump when stepping is off
  assign gainBelow = (gain_r < pgaGainTarget);
  assign gainAbove = (gain_r > pgaGainTarget);
  assign gain_nxt = immediate ? pgaGainTarget :
                    (stepNow && gainBelow) ? 7'(gain_r + 7'h01) :
                    (stepNow && gainAbove) ? 7'(gain_r - 7'h01) :
                    gain_r;

  // Flags a stray reserved code so firmware faults show up; set beats clear
  assign anyReserved = micLeftLv.reserved || micRightLv.reserved || lineLv.reserved;
  assign reserved_nxt = anyReserved ? 1'b1 :
                        reservedClear ? 1'b0 :
                        reserved_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      micReg_r <= mix_ctrl_pkg::AUX_MIC_RIGHT_RESET;
      lineReg_r <= mix_ctrl_pkg::LINE_LEFT_RESET;
    end else if (ce) begin
      micReg_r <= micReg_nxt;
      lineReg_r <= lineReg_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_r <= 8'h00;
      rdValid_r <= 1'b0;
    end else if (ce) begin
      rdData_r <= regRdEn ? rdMux : rdData_r;
      rdValid_r <= regRdEn;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_r <= mix_ctrl_pkg::PGA_GAIN_RESET;
      reserved_r <= 1'b0;
    end else if (ce) begin
      gain_r <= gain_nxt;
      reserved_r <= reserved_nxt;
    end
  end

  // Decoded mix controls are retimed so the analog side sees clean levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      micLeftConn_r <= 1'b0;
      micRightConn_r <= 1'b0;
      lineConn_r <= 1'b0;
    end else if (ce) begin
      micLeftConn_r <= micLeftLv.connected;
      micRightConn_r <= micRightLv.connected;
      lineConn_r <= lineLv.connected;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      micLeftAtten_r <= 5'h00;
      micRightAtten_r <= 5'h00;
      lineAtten_r <= 5'h00;
    end else if (ce) begin
      micLeftAtten_r <= micLeftLv.attenHalfDb;
      micRightAtten_r <= micRightLv.attenHalfDb;
      lineAtten_r <= lineLv.attenHalfDb;
    end
  end

  assign regRdData = rdData_r;
  assign regRdValid = rdValid_r;
  assign pgaGainApplied = gain_r;
  assign pgaGainSettled = (gain_r == pgaGainTarget);
  assign micLeftConnected = micLeftConn_r;
  assign micRightConnected = micRightConn_r;
  assign lineConnected = lineConn_r;
  assign micLeftAtten = micLeftAtten_r;
  assign micRightAtten = micRightAtten_r;
  assign lineAtten = lineAtten_r;
  // Both channel connections of the line share this one bit, so hardware keeps them equal
  assign lineDifferential = lineReg_r[mix_ctrl_pkg::LINE_DIFF_BIT];
  assign leftAdcPowerUp = lineReg_r[mix_ctrl_pkg::ADC_POWER_BIT];
  assign reservedCodeSeen = reserved_r;
endmodule

//--- logic/level_decode.sv
// Decoder of one 4-bit input level code
`timescale 1ns/100ps
module level_decode (
  level_if.dec lv // Code in, connection and attenuation out
);
  wire inRange;
  wire isOff;

  assign inRange = (lv.code <= mix_ctrl_pkg::LEVEL_MAX_CODE);
  assign isOff = (lv.code == mix_ctrl_pkg::LEVEL_DISCONNECT);
  // Any valid gain code connects the input by itself; all-ones disconnects
  assign lv.connected = inRange;
  // Monotonic 1.5 dB per code, so code 8 lands on 12 dB of attenuation
  assign lv.attenHalfDb = inRange ?
      5'(5'(lv.code) * mix_ctrl_pkg::ATTEN_HALF_DB_PER_CODE) : 5'h00;
  // Reserved codes leave the input unconnected rather than guessing a gain
  assign lv.reserved = !inRange && !isOff;
endmodule

//--- logic/soft_step_pacer.sv
// Pacing of left PGA gain steps against the sample rate
`timescale 1ns/100ps
module soft_step_pacer (
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic fsTick, // One-cycle pulse per sample period
  input wire mix_ctrl_pkg::step_rate_t rate, // Soft-stepping rate
  output logic stepNow, // Step the gain this cycle
  output logic immediate // Jump straight to the target
);
  logic oddTick_r;
  logic oddTick_nxt;
  wire everyFs;
  wire everyTwo;

  assign everyFs = (rate == mix_ctrl_pkg::RATE_EVERY_FS);
  assign everyTwo = (rate == mix_ctrl_pkg::RATE_EVERY_TWO_FS);
  assign immediate = !everyFs && !everyTwo;
  assign oddTick_nxt = (fsTick && everyTwo) ? !oddTick_r : oddTick_r;
  assign stepNow = ce && fsTick && (everyFs || (everyTwo && oddTick_r));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oddTick_r <= 1'b0;
    end else if (ce) begin
      oddTick_r <= oddTick_nxt;
    end
  end
endmodule

//--- verif/adc_input_mix_control_regs_sva.sv
// Port assertions for the input mix register bank
`timescale 1ns/100ps
module adc_input_mix_control_regs_sva (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic ce, // Enable
  input wire logic regWrEn, // Write
  input wire logic regRdEn, // Read
  input wire logic [7:0] regAddr, // Address
  input wire logic [7:0] regWrData, // Write data
  input wire logic [7:0] regRdData, // Read data
  input wire logic regRdValid, // Read valid
  input wire logic [6:0] pgaGainTarget, // Gain target
  input wire logic pgaGainSettled, // Gain settled
  input wire logic micLeftConnected, // Left mic on
  input wire logic [4:0] micLeftAtten, // Left mic level
  input wire logic micRightConnected, // Right mic on
  input wire logic lineDifferential, // Line mode
  input wire logic leftAdcPowerUp, // ADC power
  input wire logic reservedCodeSeen // Reserved flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire wrMic = ce && regWrEn && regAddr == 8'h12;
  wire wrLine = ce && regWrEn && regAddr == 8'h13;
  wire rdAny = ce && regRdEn;
  // Decoded outputs lag the register by one cycle, so no overwrite may follow
  sequence micLevelWr;
    wrMic && regWrData[7:4] <= 4'h8 ##1 ce && !wrMic;
  endsequence
  sequence micOffWr;
    wrMic && regWrData[3:0] == 4'hF ##1 ce && !wrMic;
  endsequence
  rd_valid_a: assert property (ce |=> regRdValid == $past(regRdEn))
    else $error("bad valid");
  unmapped_rd_a: assert property (rdAny && regAddr != 8'h12 && regAddr != 8'h13 |=>
    regRdData == 8'h00) else $error("unmapped read not zero");
  read_back_a: assert property (wrLine ##1 rdAny && regAddr == 8'h13 && !regWrEn |=>
    regRdData == $past(regWrData, 2)) else $error("read back differs");
  power_bit_a: assert property (wrLine |=> leftAdcPowerUp == $past(regWrData[2]))
    else $error("power bit wrong");
  diff_bit_a: assert property (wrLine |=> lineDifferential == $past(regWrData[7]))
    else $error("line mode wrong");
  mic_level_a: assert property (micLevelWr |=> micLeftConnected &&
    micLeftAtten == {1'b0, $past(regWrData[7:4], 2)} * 5'h03) else $error("mic level wrong");
  mic_off_a: assert property (micOffWr |=> !micRightConnected)
    else $error("right mic connected");
  reserved_flag_a: assert property (wrMic && regWrData[7:4] > 4'h8 &&
    regWrData[7:4] < 4'hF ##1 ce |=> reservedCodeSeen) else $error("reserved not flagged");
  gain_jump_a: assert property (wrLine && regWrData[1] ##1
    (ce && !wrLine && $stable(pgaGainTarget))[*3] |-> pgaGainSettled) else $error("no jump");
endmodule

//--- verif/adc_input_mix_control_regs_tb.sv
// Self-checking bench for the input mix register bank
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("mismatch %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module adc_input_mix_control_regs_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic fsTick = 1'b0;
  logic [6:0] pgaGainTarget = 7'h00;
  logic reservedClear = 1'b0;
  logic [7:0] regRdData;
  logic [6:0] pgaGainApplied;
  logic [4:0] micLeftAtten, micRightAtten, lineAtten;
  logic regRdValid, pgaGainSettled, micLeftConnected, micRightConnected;
  logic lineConnected, lineDifferential, leftAdcPowerUp, reservedCodeSeen;
  int n_mismatch = 0;
  int total_checks = 0;
  adc_input_mix_control_regs u_dut (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .regWrEn(regWrEn),
    .regRdEn(regRdEn),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regRdData(regRdData),
    .regRdValid(regRdValid),
    .fsTick(fsTick),
    .pgaGainTarget(pgaGainTarget),
    .reservedClear(reservedClear),
    .pgaGainApplied(pgaGainApplied),
    .pgaGainSettled(pgaGainSettled),
    .micLeftConnected(micLeftConnected),
    .micLeftAtten(micLeftAtten),
    .micRightConnected(micRightConnected),
    .micRightAtten(micRightAtten),
    .lineConnected(lineConnected),
    .lineAtten(lineAtten),
    .lineDifferential(lineDifferential),
    .leftAdcPowerUp(leftAdcPowerUp),
    .reservedCodeSeen(reservedCodeSeen)
  );
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    `CHK("read", {1'b1, exp}, {regRdValid, regRdData})
  endtask
  task automatic tick(input logic [6:0] exp);
    fsTick = 1'b1;
    @(negedge clk);
    fsTick = 1'b0;
    `CHK("gain", exp, pgaGainApplied)
    @(negedge clk);
  endtask
  task automatic t_reset();
    `CHK("mix", 3'b000, {micLeftConnected, micRightConnected, lineConnected})
    `CHK("mode", 2'b00, {lineDifferential, leftAdcPowerUp})
    rd(8'h12, 8'hFF);
    // Idle edge so the read strobe is not dropped and raised in one time step
    @(negedge clk);
    rd(8'h13, 8'h78);
    $display("test reset done");
  endtask
  task automatic t_levels();
    for (int c = 0; c <= 8; c++) begin
      wr(8'h12, {c[3:0], 4'(8 - c)});
      @(negedge clk);
      // Only one line connection is driven, so one configuration serves both channels
      wr(8'h13, {1'b1, c[3:0], 3'b100});
      @(negedge clk);
      `CHK("mic left", {1'b1, 5'(c * 3)}, {micLeftConnected, micLeftAtten})
      `CHK("mic right", {1'b1, 5'((8 - c) * 3)}, {micRightConnected, micRightAtten})
      `CHK("line", {1'b1, 5'(c * 3)}, {lineConnected, lineAtten})
      `CHK("mode", 2'b11, {lineDifferential, leftAdcPowerUp})
    end
    wr(8'h12, 8'hFF);
    @(negedge clk);
    wr(8'h13, 8'h78);
    rd(8'h13, 8'h78);
    `CHK("off", 3'b000, {micLeftConnected, micRightConnected, lineConnected})
    `CHK("off mode", 2'b00, {lineDifferential, leftAdcPowerUp})
    $display("test levels done");
  endtask
  task automatic t_misc();
    wr(8'h14, 8'h00);
    rd(8'h14, 8'h00);
    ce = 1'b0;
    wr(8'h12, 8'h00);
    ce = 1'b1;
    rd(8'h12, 8'hFF);
    wr(8'h12, 8'h9F);
    @(negedge clk);
    `CHK("reserved", 2'b10, {reservedCodeSeen, micLeftConnected})
    // Clear while the reserved code is still stored: the set must win
    reservedClear = 1'b1;
    @(negedge clk);
    reservedClear = 1'b0;
    `CHK("set wins", 1'b1, reservedCodeSeen)
    wr(8'h12, 8'hFF);
    reservedClear = 1'b1;
    @(negedge clk);
    reservedClear = 1'b0;
    `CHK("cleared", 1'b0, reservedCodeSeen)
    $display("test misc done");
  endtask
  task automatic t_ramp();
    pgaGainTarget = 7'h02;
    tick(7'h01);
    tick(7'h02);
    `CHK("settled", 1'b1, pgaGainSettled)
    wr(8'h13, 8'h79);
    pgaGainTarget = 7'h04;
    // First tick at the halved rate only arms the parity
    tick(7'h02);
    tick(7'h03);
    pgaGainTarget = 7'h30;
    wr(8'h13, 8'h7A);
    repeat (4) @(negedge clk);
    `CHK("jump 10", 7'h30, pgaGainApplied)
    pgaGainTarget = 7'h05;
    wr(8'h13, 8'h7B);
    repeat (4) @(negedge clk);
    `CHK("jump 11", 7'h05, pgaGainApplied)
    $display("test ramp done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    // Whole run needs well under a thousand cycles
    repeat (5000) @(posedge clk);
    n_mismatch++;
    results();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_levels();
    t_misc();
    t_ramp();
    results();
  end
endmodule
bind adc_input_mix_control_regs adc_input_mix_control_regs_sva u_sva (
  .clk(clk),
  .rst_n(rst_n),
  .ce(ce),
  .regWrEn(regWrEn),
  .regRdEn(regRdEn),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .regRdData(regRdData),
  .regRdValid(regRdValid),
  .pgaGainTarget(pgaGainTarget),
  .pgaGainSettled(pgaGainSettled),
  .micLeftConnected(micLeftConnected),
  .micLeftAtten(micLeftAtten),
  .micRightConnected(micRightConnected),
  .lineDifferential(lineDifferential),
  .leftAdcPowerUp(leftAdcPowerUp),
  .reservedCodeSeen(reservedCodeSeen)
);
